/* File: rtl/mon_pkg.sv */
package mon_pkg;

  // query leaves and sub-leaves
  localparam logic [31:0] LEAF_BASIC = 32'h0000_0000;
  localparam logic [31:0] LEAF_EXT = 32'h0000_0007;
  localparam logic [31:0] LEAF_MON = 32'h0000_000F;
  localparam logic [31:0] MAX_QUERY_LEAF = 32'h0000_000F;
  localparam logic [31:0] SUB_ENUM = 32'h0000_0000;
  localparam logic [31:0] SUB_LLC = 32'h0000_0001;

  // bit positions in query results
  localparam int CAP_FLAG_BIT = 12;
  localparam int RES_LLC_BIT = 1;
  localparam int EVT_OCC_BIT = 0;
  localparam int EVT_TOT_BIT = 1;
  localparam int EVT_LOC_BIT = 2;

  // event codes
  localparam logic [7:0] EVT_CODE_OCC = 8'h01;
  localparam logic [7:0] EVT_CODE_TOT = 8'h02;
  localparam logic [7:0] EVT_CODE_LOC = 8'h03;

  // model-specific register addresses
  localparam logic [31:0] ADDR_ASSOC = 32'h0000_0100;
  localparam logic [31:0] ADDR_EVTSEL = 32'h0000_0101;
  localparam logic [31:0] ADDR_COUNT = 32'h0000_0102;

  // field layout
  localparam int EVT_CODE_MSB = 7;
  localparam int EVT_TAG_LSB = 32;
  localparam int EVT_TAG_MSB = 41;
  localparam int CNT_ERR_BIT = 63;
  localparam int CNT_UNAV_BIT = 62;
  localparam int CNT_DATA_W = 62;
  localparam int TAG_FIELD_MAX_W = 10;
  localparam logic [63:0] ASSOC_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {EV_OCC, EV_TOT, EV_LOC, EV_RSVD} event_kind_type;

  function automatic event_kind_type decode_event(input logic [7:0] code);
    unique case (code)
      EVT_CODE_OCC: decode_event = EV_OCC;
      EVT_CODE_TOT: decode_event = EV_TOT;
      EVT_CODE_LOC: decode_event = EV_LOC;
      default: decode_event = EV_RSVD;
    endcase
  endfunction

endpackage

/* File: rtl/count_lookup_if.sv */
`timescale 1ns/1ps
interface count_lookup_if #(parameter int TAG_W = 6);
  logic [TAG_W-1:0] tag;
  logic [7:0] event_code;
  logic [61:0] data;
  logic unavail;
  logic [63:0] word;
  modport src(output tag, output event_code, output data, output unavail, input word);
  modport fmt(input tag, input event_code, input data, input unavail, output word);
endinterface

/* File: rtl/count_word_fmt.sv */
`timescale 1ns/1ps
module count_word_fmt
  import mon_pkg::*;
#(
  parameter int unsigned LLC_MAX_TAG = 63,
  parameter bit HAS_TOTAL_BW = 1'b1,
  parameter bit HAS_LOCAL_BW = 1'b1
) (
  count_lookup_if.fmt lk
);

  logic supported;
  logic err;
  logic unav;

  always_comb begin
    unique case (decode_event(lk.event_code))
      EV_OCC: supported = 1'b1;
      EV_TOT: supported = HAS_TOTAL_BW;
      EV_LOC: supported = HAS_LOCAL_BW;
      default: supported = 1'b0;
    endcase
    // tags above the cache's own range are unsupported there
    err = !supported || (int'(lk.tag) > int'(LLC_MAX_TAG));
    unav = !err && lk.unavail;
    lk.word = '0;
    lk.word[CNT_ERR_BIT] = err;
    lk.word[CNT_UNAV_BIT] = unav;
    // data is zeroed when it may not be trusted
    lk.word[CNT_DATA_W-1:0] = (err || unav) ? '0 : lk.data;
  end

endmodule // count_word_fmt

/* File: rtl/mon_enum_assoc.sv */
`timescale 1ns/1ps
module mon_enum_assoc
  import mon_pkg::*;
#(
  parameter int unsigned NUM_THREADS = 2,
  parameter int unsigned MAX_TAG = 63,
  parameter int unsigned LLC_MAX_TAG = 63,
  parameter logic [31:0] CONV_FACTOR = 32'h0000_0040,
  parameter bit HAS_TOTAL_BW = 1'b1,
  parameter bit HAS_LOCAL_BW = 1'b1,
  localparam int THR_W = (NUM_THREADS > 1) ? $clog2(NUM_THREADS) : 1,
  localparam int TAG_W = $clog2(MAX_TAG + 1)
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic QUERY_REQ_I,
  input wire logic [31:0] QUERY_LEAF_I,
  input wire logic [31:0] QUERY_SUB_I,
  output logic QUERY_ACK_O,
  output logic [31:0] QUERY_A_O,
  output logic [31:0] QUERY_B_O,
  output logic [31:0] QUERY_C_O,
  output logic [31:0] QUERY_D_O,
  input wire logic MSR_RD_I,
  input wire logic MSR_WR_I,
  input wire logic [31:0] MSR_ADDR_I,
  input wire logic [63:0] MSR_WDATA_I,
  input wire logic [THR_W-1:0] MSR_THREAD_I,
  output logic MSR_ACK_O,
  output logic MSR_GP_O,
  output logic [63:0] MSR_RDATA_O,
  input wire logic LLC_REQ_I,
  input wire logic [THR_W-1:0] LLC_THREAD_I,
  output logic LLC_REQ_O,
  output logic [TAG_W-1:0] LLC_TAG_O,
  output logic [TAG_W-1:0] CNT_TAG_O,
  output logic [7:0] CNT_EVENT_O,
  input wire logic [61:0] CNT_DATA_I,
  input wire logic CNT_UNAVAIL_I
);

  if (TAG_W < 1 || TAG_W > TAG_FIELD_MAX_W) begin : g_bad_tag
    $error("tag range does not fit the tag field");
  end
  if (LLC_MAX_TAG > MAX_TAG) begin : g_bad_llc
    $error("cache tag maximum exceeds the overall maximum");
  end
  if (NUM_THREADS != (1 << THR_W)) begin : g_bad_thr
    $error("thread count must be a power of two");
  end

  localparam logic [TAG_W-1:0] MAX_TAG_V = TAG_W'(MAX_TAG);

  typedef enum logic {ST_IDLE, ST_LOOKUP} access_state_type;

  access_state_type state_reg;
  logic [TAG_W-1:0] assoc_reg [NUM_THREADS];
  logic [TAG_W-1:0] evt_tag_reg [NUM_THREADS];
  logic [7:0] evt_code_reg [NUM_THREADS];
  logic [TAG_W-1:0] cnt_tag_reg;
  logic [7:0] cnt_code_reg;
  logic [31:0] qa_next;
  logic [31:0] qb_next;
  logic [31:0] qc_next;
  logic [31:0] qd_next;
  logic wr_go;
  logic rd_go;
  logic is_assoc;
  logic is_evtsel;
  logic is_count;
  logic assoc_bad;
  logic evt_bad;
  logic wr_fault;
  logic rd_fault;
  logic [TAG_W-1:0] w_evt_tag;
  logic [63:0] rd_word;

  count_lookup_if #(.TAG_W(TAG_W)) lk ();

  count_word_fmt #(
    .LLC_MAX_TAG(LLC_MAX_TAG),
    .HAS_TOTAL_BW(HAS_TOTAL_BW),
    .HAS_LOCAL_BW(HAS_LOCAL_BW)
  ) u_fmt (
    .lk(lk.fmt)
  );

  // one tag space for the package: lookup is by tag alone, not by thread
  assign lk.tag = cnt_tag_reg;
  assign lk.event_code = cnt_code_reg;
  assign lk.data = CNT_DATA_I;
  assign lk.unavail = CNT_UNAVAIL_I;
  assign CNT_TAG_O = cnt_tag_reg;
  assign CNT_EVENT_O = cnt_code_reg;

  // capability queries
  always_comb begin
    qa_next = '0;
    qb_next = '0;
    qc_next = '0;
    qd_next = '0;
    if (QUERY_LEAF_I == LEAF_BASIC) begin
      qa_next = MAX_QUERY_LEAF;
    end else if (QUERY_LEAF_I == LEAF_EXT && QUERY_SUB_I == SUB_ENUM) begin
      qb_next[CAP_FLAG_BIT] = 1'b1;
    end else if (QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_ENUM) begin
      qb_next = 32'(MAX_TAG);
      qd_next[RES_LLC_BIT] = 1'b1;
    end else if (QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_LLC) begin
      qb_next = CONV_FACTOR;
      qc_next = 32'(LLC_MAX_TAG);
      qd_next[EVT_OCC_BIT] = 1'b1;
      qd_next[EVT_TOT_BIT] = HAS_TOTAL_BW;
      qd_next[EVT_LOC_BIT] = HAS_LOCAL_BW;
    end
    // every other sub-leaf of the monitoring leaf stays zero
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      QUERY_ACK_O <= 1'b0;
      QUERY_A_O <= '0;
      QUERY_B_O <= '0;
      QUERY_C_O <= '0;
      QUERY_D_O <= '0;
    end else begin
      QUERY_ACK_O <= QUERY_REQ_I;
      if (QUERY_REQ_I) begin
        QUERY_A_O <= qa_next;
        QUERY_B_O <= qb_next;
        QUERY_C_O <= qc_next;
        QUERY_D_O <= qd_next;
      end
    end
  end

  // register access decode; a write wins over a read in the same cycle
  assign wr_go = MSR_WR_I && state_reg == ST_IDLE;
  assign rd_go = MSR_RD_I && !MSR_WR_I && state_reg == ST_IDLE;
  assign is_assoc = MSR_ADDR_I == ADDR_ASSOC;
  assign is_evtsel = MSR_ADDR_I == ADDR_EVTSEL;
  assign is_count = MSR_ADDR_I == ADDR_COUNT;
  assign w_evt_tag = MSR_WDATA_I[EVT_TAG_LSB +: TAG_W];

  always_comb begin
    // the service-class half is not built, so it counts as reserved here
    assoc_bad = (|(MSR_WDATA_I >> TAG_W)) || (MSR_WDATA_I[TAG_W-1:0] > MAX_TAG_V);
    evt_bad = (|MSR_WDATA_I[EVT_TAG_LSB-1:EVT_CODE_MSB+1])
      || (|(MSR_WDATA_I >> (EVT_TAG_LSB + TAG_W)))
      || (w_evt_tag > MAX_TAG_V);
    // the count register is read-only; unknown addresses fault
    wr_fault = is_assoc ? assoc_bad : (is_evtsel ? evt_bad : 1'b1);
    rd_fault = !(is_assoc || is_evtsel || is_count);
    rd_word = '0;
    if (is_assoc) begin
      rd_word[TAG_W-1:0] = assoc_reg[MSR_THREAD_I];
    end else if (is_evtsel) begin
      rd_word[EVT_CODE_MSB:0] = evt_code_reg[MSR_THREAD_I];
      rd_word[EVT_TAG_LSB +: TAG_W] = evt_tag_reg[MSR_THREAD_I];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (rd_go && is_count) state_reg <= ST_LOOKUP;
        ST_LOOKUP: state_reg <= ST_IDLE;
      endcase
    end
  end

  // the lookup takes one cycle so the accounting side sees a settled tag
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cnt_tag_reg <= '0;
      cnt_code_reg <= '0;
    end else if (rd_go && is_count) begin
      cnt_tag_reg <= evt_tag_reg[MSR_THREAD_I];
      cnt_code_reg <= evt_code_reg[MSR_THREAD_I];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MSR_ACK_O <= 1'b0;
      MSR_GP_O <= 1'b0;
      MSR_RDATA_O <= '0;
    end else begin
      MSR_ACK_O <= 1'b0;
      MSR_GP_O <= 1'b0;
      if (wr_go) begin
        MSR_ACK_O <= 1'b1;
        MSR_GP_O <= wr_fault;
      end else if (rd_go && !is_count) begin
        MSR_ACK_O <= 1'b1;
        MSR_GP_O <= rd_fault;
        MSR_RDATA_O <= rd_fault ? '0 : rd_word;
      end else if (state_reg == ST_LOOKUP) begin
        MSR_ACK_O <= 1'b1;
        MSR_RDATA_O <= lk.word;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        assoc_reg[t] <= ASSOC_RESET[TAG_W-1:0];
      end
    end else if (wr_go && is_assoc && !assoc_bad) begin
      assoc_reg[MSR_THREAD_I] <= MSR_WDATA_I[TAG_W-1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        evt_tag_reg[t] <= '0;
        evt_code_reg[t] <= '0;
      end
    end else if (wr_go && is_evtsel && !evt_bad) begin
      evt_code_reg[MSR_THREAD_I] <= MSR_WDATA_I[EVT_CODE_MSB:0];
      evt_tag_reg[MSR_THREAD_I] <= w_evt_tag;
    end
  end

  // every cache request leaves tagged with its thread's active tag
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LLC_REQ_O <= 1'b0;
      LLC_TAG_O <= '0;
    end else begin
      LLC_REQ_O <= LLC_REQ_I;
      LLC_TAG_O <= assoc_reg[LLC_THREAD_I];
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_cap_flag_set: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_EXT && QUERY_SUB_I == SUB_ENUM
    |=> QUERY_ACK_O && QUERY_B_O[CAP_FLAG_BIT]
  ) else $error("capability flag not reported");

  a_resource_bitmap: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_ENUM
    |=> QUERY_D_O != 32'h0 && !QUERY_D_O[0] && QUERY_B_O == 32'(MAX_TAG)
  ) else $error("resource vector malformed");

  a_resource_llc_bit: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_ENUM
    |=> QUERY_D_O[RES_LLC_BIT]
  ) else $error("cache resource bit missing");

  a_resource_reserved: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_ENUM
    |=> QUERY_D_O[31:2] == 30'h0
  ) else $error("unimplemented resource advertised");

  a_llc_capabilities: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_LLC
    |=> QUERY_C_O == 32'(LLC_MAX_TAG) && QUERY_D_O[EVT_OCC_BIT]
      && QUERY_D_O[EVT_TOT_BIT] == HAS_TOTAL_BW && QUERY_D_O[EVT_LOC_BIT] == HAS_LOCAL_BW
  ) else $error("cache sub-leaf fields wrong");

  a_conv_factor: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I == SUB_LLC
    |=> QUERY_B_O == CONV_FACTOR && QUERY_D_O[31:3] == 29'h0
  ) else $error("conversion factor wrong");

  a_unsupported_leaf: assert property (
    QUERY_REQ_I && QUERY_LEAF_I == LEAF_MON && QUERY_SUB_I > SUB_LLC
    |=> QUERY_A_O == 32'h0 && QUERY_B_O == 32'h0 && QUERY_C_O == 32'h0 && QUERY_D_O == 32'h0
  ) else $error("unsupported sub-leaf not zero");

  a_tag_range_fault: assert property (
    wr_go && is_assoc && MSR_WDATA_I[TAG_W-1:0] > MAX_TAG_V
    |=> MSR_ACK_O && MSR_GP_O
      && assoc_reg[$past(MSR_THREAD_I)] == $past(assoc_reg[MSR_THREAD_I])
  ) else $error("oversize tag accepted");

  a_reserved_fault: assert property (
    wr_go && is_evtsel && MSR_WDATA_I[31:8] != 24'h0 |=> MSR_ACK_O && MSR_GP_O
  ) else $error("reserved bit write accepted");

  a_count_latency: assert property (
    rd_go && is_count |=> !MSR_ACK_O ##1 MSR_ACK_O && !MSR_GP_O
  ) else $error("count read not answered in two cycles");

  a_count_error_flag: assert property (
    state_reg == ST_LOOKUP && decode_event(cnt_code_reg) == EV_RSVD
    |=> MSR_RDATA_O[CNT_ERR_BIT] && !MSR_RDATA_O[CNT_UNAV_BIT]
  ) else $error("reserved event not flagged");

  a_assoc_readback: assert property (
    rd_go && is_assoc |=> MSR_ACK_O && (MSR_RDATA_O >> TAG_W) == 64'h0
  ) else $error("association reserved bits nonzero");

  a_llc_tagging: assert property (
    wr_go && is_assoc && !assoc_bad ##1 LLC_REQ_I && LLC_THREAD_I == $past(MSR_THREAD_I)
    |=> LLC_REQ_O && LLC_TAG_O == $past(MSR_WDATA_I[TAG_W-1:0], 2)
  ) else $error("cache request tag mismatch");

endmodule // mon_enum_assoc

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb
  import mon_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic q_req = 1'b0;
  logic [31:0] q_leaf = 32'h0;
  logic [31:0] q_sub = 32'h0;
  logic q_ack;
  logic [31:0] qa, qb, qc, qd;
  logic m_rd = 1'b0;
  logic m_wr = 1'b0;
  logic [31:0] m_addr = 32'h0;
  logic [63:0] m_wdata = 64'h0;
  logic m_thr = 1'b0;
  logic m_ack, m_gp;
  logic [63:0] m_rdata;
  logic l_req = 1'b0;
  logic l_thr = 1'b0;
  logic l_req_o;
  logic [5:0] l_tag, c_tag;
  logic [7:0] c_evt;
  logic [61:0] c_data = 62'h0ABC_1234;
  logic c_unav = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h04};
  logic [63:0] sel;

  always #12.5 clk = ~clk;

  // maximums below the field's reach so range faults and cache-only limits can be hit
  mon_enum_assoc #(.MAX_TAG(47), .LLC_MAX_TAG(31)) u_dut (.CLK_I(clk), .RST_B_I(rst_b),
    .QUERY_REQ_I(q_req),
    .QUERY_LEAF_I(q_leaf), .QUERY_SUB_I(q_sub), .QUERY_ACK_O(q_ack), .QUERY_A_O(qa),
    .QUERY_B_O(qb), .QUERY_C_O(qc), .QUERY_D_O(qd), .MSR_RD_I(m_rd), .MSR_WR_I(m_wr),
    .MSR_ADDR_I(m_addr), .MSR_WDATA_I(m_wdata), .MSR_THREAD_I(m_thr), .MSR_ACK_O(m_ack),
    .MSR_GP_O(m_gp), .MSR_RDATA_O(m_rdata), .LLC_REQ_I(l_req), .LLC_THREAD_I(l_thr),
    .LLC_REQ_O(l_req_o), .LLC_TAG_O(l_tag), .CNT_TAG_O(c_tag), .CNT_EVENT_O(c_evt),
    .CNT_DATA_I(c_data), .CNT_UNAVAIL_I(c_unav));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // answer lands just after the taking edge, registered on that same edge
  task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
    @(posedge clk);
    q_req <= 1'b1;
    q_leaf <= leaf;
    q_sub <= sub;
    @(posedge clk);
    q_req <= 1'b0;
    #1;
    check({63'h0, q_ack}, 64'h1);
  endtask

  // request held until the taking edge; ack awaited under a bound
  task automatic msr(input logic wr, input logic thr, input logic [31:0] addr,
                     input logic [63:0] wd, output logic [63:0] rd, output logic gp);
    int n;
    n = 0;
    @(posedge clk);
    m_wr <= wr;
    m_rd <= !wr;
    m_thr <= thr;
    m_addr <= addr;
    m_wdata <= wd;
    @(posedge clk);
    m_wr <= 1'b0;
    m_rd <= 1'b0;
    #1;
    while (m_ack !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (m_ack !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rd = m_rdata;
    gp = m_gp;
  endtask

  task automatic wr_chk(input logic thr, input logic [31:0] addr, input logic [63:0] wd,
                        input logic exp_gp);
    logic [63:0] rd;
    logic gp;
    msr(1'b1, thr, addr, wd, rd, gp);
    check({63'h0, gp}, {63'h0, exp_gp});
  endtask

  task automatic rd_chk(input logic thr, input logic [31:0] addr, input logic [63:0] exp,
                        input logic exp_gp);
    logic [63:0] rd;
    logic gp;
    msr(1'b0, thr, addr, 64'h0, rd, gp);
    check({63'h0, gp}, {63'h0, exp_gp});
    check(rd, exp);
  endtask

  task automatic llc(input logic thr, input logic [5:0] exp_tag);
    @(posedge clk);
    l_req <= 1'b1;
    l_thr <= thr;
    @(posedge clk);
    l_req <= 1'b0;
    #1;
    check({57'h0, l_req_o, l_tag}, {57'h0, 1'b1, exp_tag});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(1'b0, ADDR_ASSOC, 64'h0, 1'b0);
    rd_chk(1'b1, ADDR_ASSOC, 64'h0, 1'b0);
    $display("test reset done");

    query(LEAF_BASIC, SUB_ENUM);
    check({qa, qb}, {32'h0000_000F, 32'h0});
    query(LEAF_EXT, SUB_ENUM);
    check({32'h0, qb}, 64'h0000_0000_0000_1000);
    query(LEAF_MON, SUB_ENUM);
    check({qb, qd}, {32'h0000_002F, 32'h0000_0002});
    query(LEAF_MON, SUB_LLC);
    check({qb, qc}, {32'h0000_0040, 32'h0000_001F});
    check({32'h0, qd}, 64'h0000_0000_0000_0007);
    query(LEAF_MON, 32'h0000_0002);
    check({qa, qb}, 64'h0);
    check({qc, qd}, 64'h0);
    $display("test query done");

    wr_chk(1'b0, ADDR_ASSOC, 64'h0000_0000_0000_0005, 1'b0);
    rd_chk(1'b0, ADDR_ASSOC, 64'h0000_0000_0000_0005, 1'b0);
    rd_chk(1'b1, ADDR_ASSOC, 64'h0, 1'b0);
    llc(1'b0, 6'h05);
    llc(1'b1, 6'h00);
    // a request right behind the write already carries the new tag
    @(posedge clk);
    m_wr <= 1'b1;
    m_thr <= 1'b0;
    m_addr <= ADDR_ASSOC;
    m_wdata <= 64'h0000_0000_0000_0009;
    @(posedge clk);
    m_wr <= 1'b0;
    l_req <= 1'b1;
    l_thr <= 1'b0;
    @(posedge clk);
    l_req <= 1'b0;
    #1;
    check({57'h0, l_req_o, l_tag}, {57'h0, 1'b1, 6'h09});
    wr_chk(1'b1, ADDR_ASSOC, 64'h0000_0000_0000_002F, 1'b0);
    llc(1'b1, 6'h2F);
    wr_chk(1'b1, ADDR_ASSOC, 64'h0000_0000_0000_0030, 1'b1);
    wr_chk(1'b1, ADDR_ASSOC, 64'h0000_0001_0000_0001, 1'b1);
    rd_chk(1'b1, ADDR_ASSOC, 64'h0000_0000_0000_002F, 1'b0);
    $display("test assoc done");

    // unknown codes are accepted on write and flagged only when counted
    for (int i = 0; i < 5; i++) begin
      sel = 64'h0000_0007_0000_0000 | {56'h0, codes[i]};
      wr_chk(1'b0, ADDR_EVTSEL, sel, 1'b0);
      rd_chk(1'b0, ADDR_EVTSEL, sel, 1'b0);
      rd_chk(1'b0, ADDR_COUNT, (i < 3) ? {2'b00, c_data} : 64'h8000_0000_0000_0000,
             1'b0);
      check({50'h0, c_tag, c_evt}, {50'h0, 6'h07, codes[i]});
    end
    c_unav <= 1'b1;
    wr_chk(1'b0, ADDR_EVTSEL, 64'h0000_0007_0000_0001, 1'b0);
    rd_chk(1'b0, ADDR_COUNT, 64'h4000_0000_0000_0000, 1'b0);
    c_unav <= 1'b0;
    wr_chk(1'b0, ADDR_EVTSEL, 64'h0000_0007_0000_0101, 1'b1);
    wr_chk(1'b0, ADDR_EVTSEL, 64'h0000_0030_0000_0001, 1'b1);
    rd_chk(1'b0, ADDR_EVTSEL, 64'h0000_0007_0000_0001, 1'b0);
    // a tag inside the overall range but above the cache's own limit
    wr_chk(1'b0, ADDR_EVTSEL, 64'h0000_0020_0000_0001, 1'b0);
    rd_chk(1'b0, ADDR_COUNT, 64'h8000_0000_0000_0000, 1'b0);
    $display("test event done");

    // the same tag on another thread addresses the same counters
    wr_chk(1'b1, ADDR_ASSOC, 64'h0000_0000_0000_0005, 1'b0);
    llc(1'b1, 6'h05);
    wr_chk(1'b1, ADDR_EVTSEL, 64'h0000_0005_0000_0002, 1'b0);
    rd_chk(1'b1, ADDR_COUNT, {2'b00, c_data}, 1'b0);
    check({50'h0, c_tag, c_evt}, {50'h0, 6'h05, 8'h02});
    wr_chk(1'b0, ADDR_COUNT, 64'h1, 1'b1);
    wr_chk(1'b0, 32'h0000_0103, 64'h1, 1'b1);
    rd_chk(1'b0, 32'h0000_0103, 64'h0, 1'b1);
    $display("test shared done");
    finish_test();
  end
endmodule // tb
